// >>> rtl/wdt_interval_timer.v
// Purpose: 8-bit watchdog / interval timer with password-protected writes.
// Assumes: Pin reset is i_rstn; bus writes and reads last one cycle.
// Notes: Read data is registered and appears one cycle after i_bus_rd.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.vh"
module wdt_interval_timer #(
  parameter [9:0] INT_RST_CYCLES = `WDT_INT_RST_STATES,
  parameter [9:0] EXT_RST_CYCLES = `WDT_EXT_RST_STATES
) (
  // Clock, pin reset and clock enable
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_ce,
  // Software standby from the power controller
  input wire i_standby,
  // Register bus
  input wire [15:0] i_bus_addr,
  input wire i_bus_wr,
  input wire i_bus_word,
  input wire [15:0] i_bus_wdata,
  input wire i_bus_rd,
  output reg [7:0] o_bus_rdata,
  // Chip reset and interrupt
  output wire o_chip_reset_n,
  output wire o_interval_irq,
  // Open-drain external reset output
  output wire o_ext_reset_out,
  output wire o_ext_reset_oe_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg overflow_flag_reg;
  reg overflow_flag_next;
  reg watchdog_mode_select_reg;
  reg watchdog_mode_select_next;
  reg timer_enable_reg;
  reg timer_enable_next;
  reg [2:0] clock_select_reg;
  reg [2:0] clock_select_next;
  reg [7:0] wdt_up_counter_reg;
  reg [7:0] wdt_up_counter_next;
  reg watchdog_reset_flag_reg;
  reg watchdog_reset_flag_next;
  reg reset_output_enable_reg;
  reg reset_output_enable_next;
  reg ovf_armed_reg;
  reg ovf_armed_next;
  reg watchdog_reset_flag_armed_reg;
  reg watchdog_reset_flag_armed_next;
  reg [7:0] rdata_next;

  wire tick;
  wire int_rst_active;
  wire ext_rst_active;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // The pin is asynchronous: it asserts at once, but its release is
  // taken through three stages so no flop leaves reset near an edge.
  reg [2:0] rst_sync_reg;
  wire core_rstn = rst_sync_reg[2] & rst_sync_reg[1];

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_reg <= 3'h0;
    end else if (i_ce) begin
      rst_sync_reg <= {rst_sync_reg[1:0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Byte writes never match, so a half-word can never unlock anything.
  wire [7:0] wr_hi = i_bus_wdata[15:8];
  wire [7:0] wr_lo = i_bus_wdata[7:0];
  wire wr_word = i_bus_wr & i_bus_word;
  wire at_cnt_csr = (i_bus_addr == `WDT_ADDR_CNT_WR);
  wire at_rst = (i_bus_addr == `WDT_ADDR_RST_WR);
  wire wr_cnt = wr_word & at_cnt_csr & (wr_hi == `WDT_PW_CNT);
  wire wr_csr = wr_word & at_cnt_csr & (wr_hi == `WDT_PW_CSR);
  wire wr_rst_clr = wr_word & at_rst & (wr_hi == `WDT_PW_RST_CLR) &
                    (wr_lo == `WDT_RST_CLR_DATA);
  wire wr_rst_oe = wr_word & at_rst & (wr_hi == `WDT_PW_RST_OE);

  wire rd_csr = i_bus_rd & (i_bus_addr == `WDT_ADDR_CSR);
  wire rd_cnt = i_bus_rd & (i_bus_addr == `WDT_ADDR_CNT);
  wire rd_rst = i_bus_rd & (i_bus_addr == `WDT_ADDR_RST_RD);

  // ----------------------------------------------------------------
  // Overflow detection
  // ----------------------------------------------------------------
  // The internal reset also resets this block, so no overflow can be
  // raised while it is still held.
  // Standby clears the counter, so it masks an overflow as well.
  wire soft_rst = int_rst_active;
  wire ovf_evt = timer_enable_reg & tick & ~wr_cnt & ~soft_rst &
                 ~i_standby &
                 (wdt_up_counter_reg == `WDT_CNT_MAX);
  wire wdt_fire = ovf_evt & watchdog_mode_select_reg;

  // ----------------------------------------------------------------
  // Prescaler and reset pulse timers
  // ----------------------------------------------------------------
  wdt_prescaler #(
    .W(12)
  ) i_wdt_prescaler (
    .i_core_clk(i_core_clk),
    .i_rstn(core_rstn),
    .i_ce(i_ce),
    .i_cks(clock_select_reg),
    .o_tick(tick)
  );

  // The pin reset clears both timers asynchronously, so a pin reset
  // arriving with an overflow always wins and leaves no stretched pulse.
  wdt_pulse_timer #(
    .W(10),
    .CYCLES(INT_RST_CYCLES)
  ) i_wdt_pulse_timer_int (
    .i_core_clk(i_core_clk),
    .i_rstn(core_rstn),
    .i_ce(i_ce),
    .i_start(wdt_fire),
    .o_active(int_rst_active)
  );

  wdt_pulse_timer #(
    .W(10),
    .CYCLES(EXT_RST_CYCLES)
  ) i_wdt_pulse_timer_ext (
    .i_core_clk(i_core_clk),
    .i_rstn(core_rstn),
    .i_ce(i_ce),
    .i_start(wdt_fire & reset_output_enable_reg),
    .o_active(ext_rst_active)
  );

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Clearing wins, then a bus write, then the tick.
  always @* begin
    wdt_up_counter_next = wdt_up_counter_reg;
    if (soft_rst | i_standby | ~timer_enable_reg) begin
      wdt_up_counter_next = `WDT_CNT_RESET;
    end else if (wr_cnt) begin
      wdt_up_counter_next = wr_lo;
    end else if (tick) begin
      wdt_up_counter_next = wdt_up_counter_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Control and status
  // ----------------------------------------------------------------
  always @* begin
    overflow_flag_next = overflow_flag_reg;
    watchdog_mode_select_next = watchdog_mode_select_reg;
    timer_enable_next = timer_enable_reg;
    clock_select_next = clock_select_reg;
    ovf_armed_next = ovf_armed_reg;
    if (soft_rst) begin
      overflow_flag_next = 1'b0;
      watchdog_mode_select_next = 1'b0;
      timer_enable_next = 1'b0;
      clock_select_next = `WDT_CKS_RESET;
      ovf_armed_next = 1'b0;
    end else if (i_standby) begin
      // The clock select is kept so a wake-up resumes the old rate.
      overflow_flag_next = 1'b0;
      watchdog_mode_select_next = 1'b0;
      timer_enable_next = 1'b0;
      ovf_armed_next = 1'b0;
    end else begin
      if (wr_csr) begin
        watchdog_mode_select_next = wr_lo[`WDT_CSR_MODE];
        timer_enable_next = wr_lo[`WDT_CSR_EN];
        clock_select_next = wr_lo[2:0];
      end
      if (rd_csr & overflow_flag_reg) begin
        ovf_armed_next = 1'b1;
      end
      // A new overflow in the clearing cycle keeps the flag set.
      if (ovf_evt) begin
        overflow_flag_next = 1'b1;
      end else if (wr_csr & ~wr_lo[`WDT_CSR_OVF] & ovf_armed_reg) begin
        overflow_flag_next = 1'b0;
        ovf_armed_next = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset status
  // ----------------------------------------------------------------
  // These two bits ignore the internal reset so that the reset routine
  // can still see why the chip restarted.
  always @* begin
    watchdog_reset_flag_next = watchdog_reset_flag_reg;
    reset_output_enable_next = reset_output_enable_reg;
    watchdog_reset_flag_armed_next = watchdog_reset_flag_armed_reg;
    if (rd_rst & watchdog_reset_flag_reg) begin
      watchdog_reset_flag_armed_next = 1'b1;
    end
    if (wdt_fire) begin
      watchdog_reset_flag_next = 1'b1;
    end else if (wr_rst_clr & watchdog_reset_flag_armed_reg) begin
      watchdog_reset_flag_next = 1'b0;
      watchdog_reset_flag_armed_next = 1'b0;
    end
    if (wr_rst_oe) begin
      reset_output_enable_next = wr_lo[`WDT_RST_OE];
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped reads return zero; otherwise the last value stands.
  always @* begin
    rdata_next = o_bus_rdata;
    if (rd_csr) begin
      rdata_next = {overflow_flag_reg, watchdog_mode_select_reg,
                    timer_enable_reg, `WDT_CSR_ONES,
                    clock_select_reg};
    end else if (rd_cnt) begin
      rdata_next = wdt_up_counter_reg;
    end else if (rd_rst) begin
      rdata_next = {watchdog_reset_flag_reg, reset_output_enable_reg,
                    `WDT_RST_ONES};
    end else if (i_bus_rd) begin
      rdata_next = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge i_core_clk or negedge core_rstn) begin
    if (!core_rstn) begin
      overflow_flag_reg <= 1'b0;
      watchdog_mode_select_reg <= 1'b0;
      timer_enable_reg <= 1'b0;
      clock_select_reg <= `WDT_CKS_RESET;
      wdt_up_counter_reg <= `WDT_CNT_RESET;
      ovf_armed_reg <= 1'b0;
      o_bus_rdata <= 8'h00;
    end else if (i_ce) begin
      overflow_flag_reg <= overflow_flag_next;
      watchdog_mode_select_reg <= watchdog_mode_select_next;
      timer_enable_reg <= timer_enable_next;
      clock_select_reg <= clock_select_next;
      wdt_up_counter_reg <= wdt_up_counter_next;
      ovf_armed_reg <= ovf_armed_next;
      o_bus_rdata <= rdata_next;
    end
  end

  // Only the pin reset reaches these bits.
  always @(posedge i_core_clk or negedge core_rstn) begin
    if (!core_rstn) begin
      watchdog_reset_flag_reg <= 1'b0;
      reset_output_enable_reg <= 1'b0;
      watchdog_reset_flag_armed_reg <= 1'b0;
    end else if (i_ce) begin
      watchdog_reset_flag_reg <= watchdog_reset_flag_next;
      reset_output_enable_reg <= reset_output_enable_next;
      watchdog_reset_flag_armed_reg <= watchdog_reset_flag_armed_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_chip_reset_n = ~int_rst_active;
  // The interrupt is a level; software lowers it by clearing the flag.
  assign o_interval_irq = overflow_flag_reg & ~watchdog_mode_select_reg &
                          timer_enable_reg;
  // Open drain: the level is always low, only the enable moves.
  assign o_ext_reset_out = 1'b0;
  assign o_ext_reset_oe_n = ~ext_rst_active;

endmodule // wdt_interval_timer
`default_nettype wire

// >>> rtl/wdt_map.vh
// Purpose: Constants for the watchdog / interval timer.
// Assumes: Byte-addressed register bus with 16-bit word writes.
// Notes: Definitions only; included by its bare name.
//
// How it works
// - Watchdog overflow reset sets the reset flag; pin reset or read-then-zero clears.
// - Reset flag and output enable reset only by the reset pin.
// - Output enable set drives the reset pin low; clear keeps it released.
// - Reset status bits 5 to 0 are read-only and read as 1.
// - Counter and control written only by word writes with matching password.
// - Word with A5 upper and 00 lower clears the reset flag.
// - Word with 5A upper loads output enable; byte writes do nothing.
// - Byte reads: control at FFA8, counter at FFA9, reset status FFAB.
// - Watchdog mode overflow holds the internal chip reset for 518 cycles.
// - External reset output is driven for 132 cycles when enabled.
// - Simultaneous pin and watchdog reset counts as a pin reset.
// - Same vector for both resets; only the reset flag tells them apart.
// - Interval mode requests an interrupt at every counter overflow.
// - Overflow sets the overflow flag and, same cycle, reset or interrupt.
// - Reset flag sets only in watchdog mode; internal reset clears control and counter, not the reset flag.
// - Interval interrupt requested whenever the overflow flag is 1 in interval mode with the timer enabled.
// - Counter write in the same cycle as a tick wins; no increment.
// - Clock select picks divide by 2,32,64,128,256,512,2048,4096.
// - Counter cleared and held while disabled or reset; counts up when enabled.
// - Overflow flag clears by read as 1 then write of 0, and also by internal reset or standby.
// - Control bits 7 to 5 clear in standby; clock select retained.
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

`define WDT_ADDR_CSR 16'hFFA8
`define WDT_ADDR_CNT 16'hFFA9
`define WDT_ADDR_RST_WR 16'hFFAA
`define WDT_ADDR_RST_RD 16'hFFAB
`define WDT_ADDR_CNT_WR 16'hFFA8

`define WDT_PW_CNT 8'h5A
`define WDT_PW_CSR 8'hA5
`define WDT_PW_RST_OE 8'h5A
`define WDT_PW_RST_CLR 8'hA5
`define WDT_RST_CLR_DATA 8'h00

`define WDT_CSR_OVF 7
`define WDT_CSR_MODE 6
`define WDT_CSR_EN 5
`define WDT_CSR_ONES 2'h3
`define WDT_RST_WATCHDOG_RESET_FLAG 7
`define WDT_RST_OE 6
`define WDT_RST_ONES 6'h3F

`define WDT_CNT_RESET 8'h00
`define WDT_CNT_MAX 8'hFF
`define WDT_CKS_RESET 3'h0

// Durations in system clock states: 518 and 132.
`define WDT_INT_RST_STATES 10'h206
`define WDT_EXT_RST_STATES 10'h084

`endif

// >>> rtl/wdt_prescaler.v
// Purpose: Free-running prescaler giving a one-cycle counter tick.
// Assumes: Clock enable freezes the divider.
// Notes: Tick is registered, so it lags the divider by one cycle.
`timescale 1ns/10ps
`default_nettype none
module wdt_prescaler #(
  parameter W = 12
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_ce,
  // Select and tick
  input wire [2:0] i_cks,
  output reg o_tick
);
  reg [W-1:0] div_reg;
  reg [W-1:0] mask;

  // ----------------------------------------------------------------
  // Divider select
  // ----------------------------------------------------------------
  always @* begin
    case (i_cks)
      3'h0: mask = 12'h001;
      3'h1: mask = 12'h01F;
      3'h2: mask = 12'h03F;
      3'h3: mask = 12'h07F;
      3'h4: mask = 12'h0FF;
      3'h5: mask = 12'h1FF;
      3'h6: mask = 12'h7FF;
      3'h7: mask = 12'hFFF;
      default: mask = 12'h001;
    endcase
  end

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_reg <= {W{1'b0}};
      o_tick <= 1'b0;
    end else if (i_ce) begin
      div_reg <= div_reg + 1'b1;
      o_tick <= ((div_reg & mask) == mask);
    end
  end
endmodule // wdt_prescaler
`default_nettype wire

// >>> rtl/wdt_pulse_timer.v
// Purpose: Stretches a start pulse to a fixed number of active cycles.
// Assumes: Starts while already active are ignored.
// Notes: Used for both the internal and the external reset pulse.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.vh"
module wdt_pulse_timer #(
  parameter W = 10,
  parameter [W-1:0] CYCLES = `WDT_INT_RST_STATES
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_ce,
  // Control
  input wire i_start,
  output reg o_active
);
  localparam [W-1:0] LAST = CYCLES - 1'b1;
  reg [W-1:0] cnt_reg;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= {W{1'b0}};
      o_active <= 1'b0;
    end else if (i_ce) begin
      if (o_active) begin
        if (cnt_reg == LAST) begin
          o_active <= 1'b0;
          cnt_reg <= {W{1'b0}};
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end else if (i_start) begin
        o_active <= 1'b1;
        cnt_reg <= {W{1'b0}};
      end
    end
  end
endmodule // wdt_pulse_timer
`default_nettype wire

// >>> tb/wdt_interval_timer_asserts.sv
// Purpose: Port-level assertions for the watchdog / interval timer.
// Assumes: Clock enable stays high while a reset pulse runs.
// Notes: Pulse lengths are checked with small cycle counters.
`timescale 1ns/10ps
`default_nettype none
module wdt_interval_timer_asserts #(
  parameter [9:0] INT_RST_CYCLES = 10'h206,
  parameter [9:0] EXT_RST_CYCLES = 10'h084
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_standby,
  // Register bus
  input wire logic [15:0] i_bus_addr,
  input wire logic i_bus_wr,
  input wire logic i_bus_word,
  input wire logic [15:0] i_bus_wdata,
  input wire logic i_bus_rd,
  input wire logic [7:0] o_bus_rdata,
  // Reset and interrupt outputs
  input wire logic o_chip_reset_n,
  input wire logic o_interval_irq,
  input wire logic o_ext_reset_out,
  input wire logic o_ext_reset_oe_n
);
  // ----------------------------------------
  // Pulse length counters
  // ----------------------------------------
  logic [9:0] int_cnt;
  logic [9:0] ext_cnt;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      int_cnt <= 10'h000;
      ext_cnt <= 10'h000;
    end else if (i_ce) begin
      int_cnt <= o_chip_reset_n ? 10'h000 : int_cnt + 10'h001;
      ext_cnt <= o_ext_reset_oe_n ? 10'h000 : ext_cnt + 10'h001;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_int_start;
    $fell(o_chip_reset_n);
  endsequence
  sequence s_ext_start;
    $fell(o_ext_reset_oe_n);
  endsequence
  sequence s_read(a);
    i_bus_rd && i_bus_addr == a;
  endsequence
  chk_int_rst_len: assert property (
    $rose(o_chip_reset_n) |-> int_cnt == INT_RST_CYCLES)
    else $error("internal reset pulse has the wrong length");
  chk_int_rst_cap: assert property (
    !o_chip_reset_n |-> int_cnt < INT_RST_CYCLES)
    else $error("internal reset pulse runs too long");
  chk_ext_rst_len: assert property (
    $rose(o_ext_reset_oe_n) |-> ext_cnt == EXT_RST_CYCLES)
    else $error("external reset pulse has the wrong length");
  chk_ext_rst_cap: assert property (
    !o_ext_reset_oe_n |-> ext_cnt < EXT_RST_CYCLES)
    else $error("external reset pulse runs too long");
  chk_ext_with_int: assert property (
    s_ext_start |-> s_int_start)
    else $error("external reset started without internal reset");
  chk_ext_in_int: assert property (
    !o_ext_reset_oe_n |-> !o_chip_reset_n)
    else $error("external reset driven outside internal reset");
  chk_ext_drive_low: assert property (
    o_ext_reset_out == 1'h0)
    else $error("external reset pin level is not low");
  chk_irq_no_reset: assert property (
    o_interval_irq |-> o_chip_reset_n)
    else $error("interrupt raised during chip reset");
  chk_irq_hold: assert property (
    o_interval_irq && !i_bus_wr && !i_standby |=> o_interval_irq)
    else $error("interrupt request dropped without a write");
  chk_rdata_stable: assert property (
    !i_bus_rd |=> $stable(o_bus_rdata))
    else $error("read data changed without a read");
  chk_rst_ones: assert property (
    s_read(16'hFFAB) |=> o_bus_rdata[5:0] == 6'h3F)
    else $error("reset status low bits not all ones");
endmodule // wdt_interval_timer_asserts

bind wdt_interval_timer wdt_interval_timer_asserts #(
  .INT_RST_CYCLES(INT_RST_CYCLES), .EXT_RST_CYCLES(EXT_RST_CYCLES)
) i_wdt_interval_timer_asserts (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(i_ce),
  .i_standby(i_standby), .i_bus_addr(i_bus_addr), .i_bus_wr(i_bus_wr),
  .i_bus_word(i_bus_word), .i_bus_wdata(i_bus_wdata),
  .i_bus_rd(i_bus_rd), .o_bus_rdata(o_bus_rdata),
  .o_chip_reset_n(o_chip_reset_n), .o_interval_irq(o_interval_irq),
  .o_ext_reset_out(o_ext_reset_out), .o_ext_reset_oe_n(o_ext_reset_oe_n)
);
`default_nettype wire

// >>> tb/wdt_interval_timer_tb.sv
// Purpose: Self-checking bench for the watchdog / interval timer.
// Assumes: Reset pulses shortened to 8 and 4 cycles.
// Notes: Clock enable drops once; counter reads use the slowest tick.
`timescale 1ns/10ps
`default_nettype none
module wdt_interval_timer_tb;
  logic i_core_clk = 1'h0;
  logic i_rstn = 1'h0;
  logic i_ce = 1'h1;
  logic i_standby = 1'h0;
  logic [15:0] i_bus_addr = 16'h0000;
  logic i_bus_wr = 1'h0;
  logic i_bus_word = 1'h0;
  logic [15:0] i_bus_wdata = 16'h0000;
  logic i_bus_rd = 1'h0;
  wire [7:0] o_bus_rdata;
  wire o_chip_reset_n;
  wire o_interval_irq;
  wire o_ext_reset_out;
  wire o_ext_reset_oe_n;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] cnt_val;
  logic [7:0] pw;
  logic [7:0] data;
  logic wd;

  wdt_interval_timer #(.INT_RST_CYCLES(10'h008), .EXT_RST_CYCLES(10'h004))
  i_wdt_interval_timer (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_standby(i_standby), .i_bus_addr(i_bus_addr), .i_bus_wr(i_bus_wr),
    .i_bus_word(i_bus_word), .i_bus_wdata(i_bus_wdata),
    .i_bus_rd(i_bus_rd), .o_bus_rdata(o_bus_rdata),
    .o_chip_reset_n(o_chip_reset_n), .o_interval_irq(o_interval_irq),
    .o_ext_reset_out(o_ext_reset_out), .o_ext_reset_oe_n(o_ext_reset_oe_n)
  );

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    forever #50 i_core_clk = ~i_core_clk;
  end
  // The whole run needs a few hundred cycles; this leaves a wide margin.
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] addr, input logic [15:0] wdata,
                    input logic word);
    @(posedge i_core_clk);
    i_bus_addr <= addr;
    i_bus_wdata <= wdata;
    i_bus_word <= word;
    i_bus_wr <= 1'h1;
    @(posedge i_core_clk);
    i_bus_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
    @(posedge i_core_clk);
    i_bus_addr <= addr;
    i_bus_rd <= 1'h1;
    @(posedge i_core_clk);
    i_bus_rd <= 1'h0;
    #1;
    check("read data", {8'h00, o_bus_rdata}, {8'h00, exp});
  endtask
  task automatic wait_for(input logic irq_sel, input logic lvl);
    int n = 0;
    while (((irq_sel ? o_interval_irq : o_chip_reset_n) !== lvl)
           && n < 2000) begin
      @(posedge i_core_clk);
      #1;
      n++;
    end
    check("wait level", {15'h0000, irq_sel ? o_interval_irq : o_chip_reset_n},
          {15'h0000, lvl});
  endtask
  task automatic pin_reset;
    @(posedge i_core_clk);
    i_rstn <= 1'h0;
    repeat (3) @(posedge i_core_clk);
    i_rstn <= 1'h1;
    repeat (3) @(posedge i_core_clk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cnt_val = 8'($urandom(32'hF5DA1677));
    pin_reset();
    rd(16'hFFA8, 8'h18);
    rd(16'hFFA9, 8'h00);
    rd(16'hFFAB, 8'h3F);
    rd(16'hFFAA, 8'h00);
    check("ext enable", {15'h0000, o_ext_reset_oe_n}, 16'h0001);
    // Slowest tick keeps the counter still while it is read back.
    wr(16'hFFA8, 16'hA507, 1'h1);
    wr(16'hFFA8, 16'hA527, 1'h1);
    rd(16'hFFA8, 8'h3F);
    cnt_val = 8'h00;
    for (int k = 0; k < 8; k++) begin
      wd = (k == 2) ? 1'h0 : (k < 2) ? 1'h1 : 1'($urandom_range(0, 1));
      pw = (k == 0 || k == 2) ? 8'h5A : (k == 1) ? 8'h3C :
           ($urandom_range(0, 1) ? 8'h5A : {1'h0, 7'($urandom)});
      data = 8'($urandom);
      wr(16'hFFA8, {pw, data}, wd);
      if (wd && pw == 8'h5A) cnt_val = data;
      rd(16'hFFA9, cnt_val);
    end
    wr(16'hFFA8, 16'hA500, 1'h0);
    rd(16'hFFA8, 8'h3F);
    // Interval mode overflow, clear needs a prior read.
    wr(16'hFFA8, 16'hA500, 1'h1);
    wr(16'hFFA8, 16'hA520, 1'h1);
    wr(16'hFFA8, 16'h5AF0, 1'h1);
    wait_for(1'h1, 1'h1);
    wr(16'hFFA8, 16'hA520, 1'h1);
    check("irq", {15'h0000, o_interval_irq}, 16'h0001);
    rd(16'hFFA8, 8'hB8);
    wr(16'hFFA8, 16'hA520, 1'h1);
    check("irq", {15'h0000, o_interval_irq}, 16'h0000);
    // Watchdog overflow with external output.
    wr(16'hFFAA, 16'h5A40, 1'h1);
    wr(16'hFFAA, 16'h5A00, 1'h0);
    rd(16'hFFAB, 8'h7F);
    wr(16'hFFA8, 16'hA500, 1'h1);
    wr(16'hFFA8, 16'hA560, 1'h1);
    wr(16'hFFA8, 16'h5AF0, 1'h1);
    wait_for(1'h0, 1'h0);
    check("ext enable", {15'h0000, o_ext_reset_oe_n}, 16'h0000);
    wait_for(1'h0, 1'h1);
    rd(16'hFFA8, 8'h18);
    wr(16'hFFAA, 16'hA500, 1'h1);
    rd(16'hFFAB, 8'hFF);
    wr(16'hFFAA, 16'hA500, 1'h1);
    rd(16'hFFAB, 8'h7F);
    // Watchdog overflow with external output off.
    wr(16'hFFAA, 16'h5A00, 1'h1);
    wr(16'hFFA8, 16'hA560, 1'h1);
    wr(16'hFFA8, 16'h5AF0, 1'h1);
    wait_for(1'h0, 1'h0);
    repeat (6) begin
      @(posedge i_core_clk);
      #1;
      check("ext enable", {15'h0000, o_ext_reset_oe_n}, 16'h0001);
    end
    wait_for(1'h0, 1'h1);
    rd(16'hFFAB, 8'hBF);
    // Pin reset clears the flags that survive a watchdog reset.
    wr(16'hFFAA, 16'h5A40, 1'h1);
    pin_reset();
    rd(16'hFFAB, 8'h3F);
    // Standby keeps only the clock select.
    wr(16'hFFA8, 16'hA505, 1'h1);
    wr(16'hFFA8, 16'hA525, 1'h1);
    @(posedge i_core_clk);
    i_standby <= 1'h1;
    @(posedge i_core_clk);
    i_standby <= 1'h0;
    rd(16'hFFA8, 8'h1D);
    rd(16'hFFA9, 8'h00);
    // Clock enable low freezes the block, so a counter write is lost.
    wr(16'hFFA8, 16'hA527, 1'h1);
    wr(16'hFFA8, 16'h5A33, 1'h1);
    @(posedge i_core_clk);
    i_ce <= 1'h0;
    wr(16'hFFA8, 16'h5A77, 1'h1);
    @(posedge i_core_clk);
    i_ce <= 1'h1;
    rd(16'hFFA9, 8'h33);
    give_verdict();
  end
endmodule // wdt_interval_timer_tb
`default_nettype wire
